// ---- voice_port_pkg.sv ----
// Purpose: Shared constants of the voice sample serial port
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Link reference clock sets all bit-clock divider counts

// ************************************************************
// Package
// ************************************************************
package voice_port_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;  // Control word
    localparam logic [7:0] TXD_OFS  = 8'h04;  // Outgoing sample
    localparam logic [7:0] RXD_OFS  = 8'h08;  // Incoming sample
    localparam logic [7:0] STAT_OFS = 8'h0C;  // Status

    // Control field layout
    localparam int CTRL_EN_BIT     = 0;  // Port enable
    localparam int CTRL_MASTER_BIT = 1;  // Clock master role
    localparam int CTRL_AUX_BIT    = 2;  // Long frame sync mode
    localparam int CTRL_RATE_LSB   = 3;  // Bit-clock rate code
    localparam int CTRL_W          = 6;  // Control width

    // Control reset: enabled, master, short sync, 2048 kHz
    localparam logic [5:0] CTRL_RST = 6'h1B;

    // Status field layout
    localparam int STAT_RXV_BIT    = 0;  // Fresh incoming sample
    localparam int STAT_BUSY_BIT   = 1;  // Outgoing sample in transit
    localparam int STAT_MASTER_BIT = 2;  // Effective master role
    localparam int STAT_AUX_BIT    = 3;  // Long frame sync selected

    // Bit-clock rate codes
    localparam logic [2:0] RATE_256K  = 3'h0;
    localparam logic [2:0] RATE_2048K = 3'h3;
    localparam logic [2:0] RATE_4096K = 3'h4;

    // Timing: link reference and derived counts
    localparam int LINK_REF_KHZ   = 16384;                       // Link reference clock
    localparam int BCLK_MIN_KHZ   = 256;                         // Slowest bit clock
    localparam int FS_BASE_KHZ    = 8;                           // Base frame rate
    localparam int HALF_MAX       = LINK_REF_KHZ / (2 * BCLK_MIN_KHZ);  // Half period at 256 kHz
    localparam int FRAME_BITS_MIN = BCLK_MIN_KHZ / FS_BASE_KHZ;  // Slots per frame at 256 kHz
    localparam int FRAME_BITS_MAX = 256;                          // Slots per frame, top rate
    localparam int WORD_BITS      = 16;                           // Linear sample width

endpackage

// ---- sync_2ff.sv ----
// Purpose: Two-stage synchroniser for signals entering a clock domain
// Assumes: Multi-bit use only for quasi-static levels
// Notes:   First stage feeds only the second stage

`timescale 1ns/1ps

// ************************************************************
// Synchroniser
// ************************************************************
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;  // First stage, read only by q

    // Two flops in series
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// ---- voice_sample_serial_port.sv ----
// Purpose: Serial voice-sample port to an external audio codec, APB control
// Assumes: link_clk is a free-running reference for the serial side
// Notes:   Serial logic runs on link_clk; registers run on pclk
//
// Operation
// [R1] Short sync mode, master or slave
// [R2] Long sync mode forced to master
// [R3] Short mode: launch rising, sample falling
// [R4] Short mode: sync falling edge marks MSB
// [R5] Short mode rates 256k-2048k/8k, 4096k/16k
// [R6] Long mode: launch rising, sample falling
// [R7] Long mode: sync rising edge marks MSB
// [R8] Long mode: 256k-2048k, 8k half-duty sync
// [R9] Samples are 16-bit linear words
// [R10] Master drives clock/sync; slave receives them
// [R11] Reset: master, short sync, 2048k, 8k
// [R12] Mode, role, rate set at run time
// [R13] Sixteen bits MSB first, other slots empty
// [R14] Slave codec supplies clock and sync
//
// The implementer's own choices: the APB interface to the registers and the register offsets.

`timescale 1ns/1ps

module voice_sample_serial_port
    import voice_port_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_clk,
    input  wire logic        bclk_i,
    output logic             bclk_o,
    output logic             bclk_oe_n,
    input  wire logic        fsync_i,
    output logic             fsync_o,
    output logic             fsync_oe_n,
    input  wire logic        din,
    output logic             dout
);

    // ************************************************************
    // Register side (pclk)
    // ************************************************************
    logic [CTRL_W-1:0]    ctrl_r;      // Control word
    logic [WORD_BITS-1:0] tx_data_r;   // Outgoing sample
    logic                 tx_req_r;    // Outgoing handshake toggle
    logic [WORD_BITS-1:0] rx_data_r;   // Last incoming sample
    logic                 rx_valid_r;  // Fresh sample flag
    logic                 rx_seen_r;   // Last handled incoming toggle
    logic                 tx_ack_s;    // Synced acknowledge
    logic                 rx_tgl_s;    // Synced incoming toggle
    logic [WORD_BITS-1:0] rx_word_l;   // Incoming word, stable a frame

    // Decode and selection
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable & pready;
    wire sel_ctrl  = (paddr == CTRL_OFS);
    wire sel_txd   = (paddr == TXD_OFS);
    wire sel_rxd   = (paddr == RXD_OFS);
    wire sel_stat  = (paddr == STAT_OFS);
    wire mapped    = sel_ctrl | sel_txd | sel_rxd | sel_stat;
    wire tx_busy   = tx_req_r ^ tx_ack_s;
    wire rx_new    = rx_tgl_s ^ rx_seen_r;
    wire wr_ctrl   = access_ph & pwrite & sel_ctrl;
    wire wr_txd    = access_ph & pwrite & sel_txd & ~tx_busy;
    wire rd_rxd    = access_ph & ~pwrite & sel_rxd;
    wire eff_master_p = ctrl_r[CTRL_MASTER_BIT] | ctrl_r[CTRL_AUX_BIT];
    wire [3:0] stat_w = {ctrl_r[CTRL_AUX_BIT], eff_master_p, tx_busy, rx_valid_r};
    wire [31:0] rd_mux = sel_ctrl ? {26'h0, ctrl_r} :
                         sel_txd  ? {16'h0, tx_data_r} :
                         sel_rxd  ? {16'h0, rx_data_r} :
                         sel_stat ? {28'h0, stat_w} : 32'h0;

    // APB answer: data and error prepared in setup, ready always after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'h0;
            pready  <= 1'h0;
        end else begin
            pready <= 1'h1;
            if (setup_ph) begin
                prdata  <= pwrite ? 32'h0 : rd_mux;
                pslverr <= ~mapped | (pwrite & sel_txd & tx_busy);
            end
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_r <= CTRL_RST;  // [R11]
        else if (wr_ctrl)
            ctrl_r <= pwdata[CTRL_W-1:0];  // [R12]
    end

    // Outgoing sample and its handshake toggle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_r <= 16'h0;
            tx_req_r  <= 1'h0;
        end else if (wr_txd) begin
            tx_data_r <= pwdata[WORD_BITS-1:0];  // [R9]
            tx_req_r  <= ~tx_req_r;
        end
    end

    // Incoming sample capture; a new sample beats a clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_r  <= 16'h0;
            rx_valid_r <= 1'h0;
            rx_seen_r  <= 1'h0;
        end else begin
            rx_seen_r <= rx_tgl_s;
            if (rx_new) begin
                rx_data_r  <= rx_word_l;
                rx_valid_r <= 1'h1;
            end else if (rd_rxd) begin
                rx_valid_r <= 1'h0;
            end
        end
    end

    // ************************************************************
    // Crossings
    // ************************************************************
    logic                 lrst_meta_r;  // Link reset release, first stage
    logic                 lrst_n;       // Link reset, synchronous release
    logic [CTRL_W-1:0]    cfg_l;        // Control in link domain
    logic [2:0]           pin_s;        // Synced clock, sync, data pins
    logic                 tx_req_s;     // Synced request toggle
    logic                 tx_ack_l;     // Acknowledge toggle
    logic                 rx_tgl_l;     // Incoming word toggle

    // Link reset: assert at once, release on link_clk
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            lrst_meta_r <= 1'h0;
            lrst_n      <= 1'h0;
        end else begin
            lrst_meta_r <= 1'h1;
            lrst_n      <= lrst_meta_r;
        end
    end

    sync_2ff #(.WIDTH(CTRL_W)) u_cfg_sync (
        .clk(link_clk), .rst_n(lrst_n), .d(ctrl_r), .q(cfg_l));
    sync_2ff #(.WIDTH(3)) u_pin_sync (
        .clk(link_clk), .rst_n(lrst_n), .d({bclk_i, fsync_i, din}), .q(pin_s));
    sync_2ff #(.WIDTH(1)) u_req_sync (
        .clk(link_clk), .rst_n(lrst_n), .d(tx_req_r), .q(tx_req_s));
    sync_2ff #(.WIDTH(1)) u_ack_sync (
        .clk(pclk), .rst_n(presetn), .d(tx_ack_l), .q(tx_ack_s));
    sync_2ff #(.WIDTH(1)) u_rx_sync (
        .clk(pclk), .rst_n(presetn), .d(rx_tgl_l), .q(rx_tgl_s));

    // ************************************************************
    // Link side (link_clk)
    // ************************************************************
    logic [5:0]           hcnt_r;     // Half bit-clock counter
    logic                 bclk_r;     // Generated bit clock
    logic                 bclk_prev_r;// Last synced pin clock
    logic                 fs_prev_r;  // Sync seen at last rising edge
    logic [7:0]           slot_r;     // Bit slot within frame
    logic [WORD_BITS-1:0] tx_cur_l;   // Sample for next frame
    logic [WORD_BITS-1:0] tx_sh_r;    // Outgoing shifter
    logic [WORD_BITS-1:0] rx_sh_r;    // Incoming shifter
    logic [1:0]           fall_dly_r; // Master falling edge, aged as far as din sync

    // Effective mode; long sync has no slave form, top rate is short sync only
    wire       en_l      = cfg_l[CTRL_EN_BIT];
    wire       aux_l     = cfg_l[CTRL_AUX_BIT];
    wire       master_l  = cfg_l[CTRL_MASTER_BIT] | aux_l;  // [R2]
    wire [2:0] rate_raw  = cfg_l[CTRL_RATE_LSB +: 3];
    wire       rate_bad  = (rate_raw > RATE_4096K) | (aux_l & (rate_raw == RATE_4096K));  // [R8]
    wire [2:0] rate_l    = rate_bad ? RATE_2048K : rate_raw;
    wire       top_rate  = (rate_l == RATE_4096K);
    wire [5:0] half_l    = 6'(HALF_MAX >> rate_l);  // [R5]
    wire [8:0] fbits_l   = top_rate ? 9'(FRAME_BITS_MAX) : 9'(9'(FRAME_BITS_MIN) << rate_l);
    wire [7:0] flast_l   = 8'(fbits_l - 9'h1);
    wire [7:0] fhalf_l   = 8'(fbits_l >> 1);
    wire       run_m     = en_l & master_l;
    wire       tick_m    = run_m & (hcnt_r == half_l - 6'h1);
    wire       rise_s    = en_l & ~master_l & pin_s[2] & ~bclk_prev_r;  // [R14]
    wire       fall_s    = en_l & ~master_l & ~pin_s[2] & bclk_prev_r;
    wire       rise_ev   = master_l ? (tick_m & ~bclk_r) : rise_s;
    wire       fall_ev   = master_l ? fall_dly_r[1] : fall_s;
    wire       start_ev  = master_l ? (slot_r >= flast_l) : (fs_prev_r & ~pin_s[1]);  // [R1] [R4]
    wire [7:0] slot_nxt  = start_ev ? 8'h00 : ((slot_r == 8'hFF) ? slot_r : slot_r + 8'h01);
    wire       fsync_nxt = aux_l ? (slot_nxt < fhalf_l) : (slot_nxt == flast_l);  // [R7]
    wire       word_slot = (slot_nxt < 8'(WORD_BITS));

    // Bit-clock generator, master only
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            hcnt_r <= 6'h0;
            bclk_r <= 1'h0;
        end else if (!run_m) begin
            hcnt_r <= 6'h0;
            bclk_r <= 1'h0;
        end else if (tick_m) begin
            hcnt_r <= 6'h0;
            bclk_r <= ~bclk_r;  // [R5]
        end else begin
            hcnt_r <= hcnt_r + 6'h1;
        end
    end

    // Master sample point: two cycles late, so synced din shows the bit at the pin's fall
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n)
            fall_dly_r <= 2'h0;
        else
            fall_dly_r <= {fall_dly_r[0], tick_m & bclk_r};  // [R3] [R6]
    end

    // Pin drivers and enables; slave leaves clock and sync undriven
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            bclk_o     <= 1'h0;
            bclk_oe_n  <= 1'h1;
            fsync_oe_n <= 1'h1;
        end else begin
            bclk_o     <= bclk_r;
            bclk_oe_n  <= ~run_m;  // [R10]
            fsync_oe_n <= ~run_m;  // [R10]
        end
    end

    // Slot counter and frame sync at each rising edge
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            slot_r      <= 8'hFF;
            fsync_o     <= 1'h0;
            bclk_prev_r <= 1'h0;
            fs_prev_r   <= 1'h0;
        end else begin
            bclk_prev_r <= pin_s[2];
            if (!en_l) begin
                slot_r  <= 8'hFF;
                fsync_o <= 1'h0;
            end else if (rise_ev) begin
                slot_r    <= slot_nxt;
                fs_prev_r <= pin_s[1];
                fsync_o   <= run_m & fsync_nxt;  // [R8]
            end
        end
    end

    // Outgoing word: handshake capture, launch on rising edges
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            tx_cur_l <= 16'h0;
            tx_ack_l <= 1'h0;
            tx_sh_r  <= 16'h0;
            dout     <= 1'h0;
        end else begin
            if (tx_req_s != tx_ack_l) begin
                tx_cur_l <= tx_data_r;
                tx_ack_l <= tx_req_s;
            end
            if (!en_l) begin
                dout <= 1'h0;
            end else if (rise_ev) begin  // [R3] [R6]
                if (start_ev) begin
                    dout    <= tx_cur_l[WORD_BITS-1];  // [R13]
                    tx_sh_r <= {tx_cur_l[WORD_BITS-2:0], 1'h0};
                end else begin
                    dout    <= word_slot & tx_sh_r[WORD_BITS-1];  // [R13]
                    tx_sh_r <= {tx_sh_r[WORD_BITS-2:0], 1'h0};
                end
            end
        end
    end

    // Incoming word: sample on falling edges, hand over at slot 15
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            rx_sh_r   <= 16'h0;
            rx_word_l <= 16'h0;
            rx_tgl_l  <= 1'h0;
        end else if (fall_ev && slot_r < 8'(WORD_BITS)) begin  // [R3] [R6]
            rx_sh_r <= {rx_sh_r[WORD_BITS-2:0], pin_s[0]};
            if (slot_r == 8'(WORD_BITS - 1)) begin
                rx_word_l <= {rx_sh_r[WORD_BITS-2:0], pin_s[0]};  // [R9]
                rx_tgl_l  <= ~rx_tgl_l;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_ctrl_reset: assert property (@(posedge pclk) disable iff (!presetn)  // [R11]
        !$past(presetn) |-> ctrl_r == CTRL_RST) else $error("control not at reset value");
    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)  // [R12]
        wr_ctrl |=> ctrl_r == $past(pwdata[CTRL_W-1:0])) else $error("control write lost");
    a_aux_master: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R2]
        (en_l && aux_l) [*2] |-> !bclk_oe_n) else $error("long sync mode not driving clock");
    a_slave_release: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R10]
        !run_m [*2] |-> bclk_oe_n && fsync_oe_n) else $error("slave drives clock or sync");
    a_launch_rise: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R3]
        $changed(dout) && $past(en_l) |-> $past(rise_ev)) else $error("data launched off rising edge");
    a_sample_fall: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R6]
        $changed(rx_sh_r) |-> $past(fall_ev)) else $error("data sampled off falling edge");
    a_msb_first: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R13]
        en_l && rise_ev && start_ev |=> dout == $past(tx_cur_l[WORD_BITS-1])) else $error("MSB not first");
    a_quiet_slot: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R13]
        en_l && slot_r >= 8'(WORD_BITS) && slot_r != 8'hFF |-> !dout) else $error("data outside word");
    a_pri_sync: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R4]
        run_m && !aux_l && $fell(fsync_o) |-> slot_r == 8'h00) else $error("short sync fell off MSB");
    a_aux_sync: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R7]
        run_m && aux_l && $rose(fsync_o) |-> slot_r == 8'h00) else $error("long sync rose off MSB");
    a_aux_duty: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R8]
        run_m && aux_l && rise_ev |=> fsync_o == (slot_r < fhalf_l)) else $error("long sync duty wrong");
    a_bclk_half: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R5]
        run_m && $changed(bclk_r) && $past(run_m) |-> $past(hcnt_r) == half_l - 6'h1)
        else $error("bit clock half period wrong");
    a_word_done: assert property (@(posedge link_clk) disable iff (!lrst_n)  // [R9]
        $changed(rx_tgl_l) |-> $past(slot_r) == 8'(WORD_BITS - 1)) else $error("word not 16 bits");

endmodule

// ---- codec_model.sv ----
// Purpose: Behavioural audio codec on the far side of the voice port
// Assumes: Short sync unless aux is set; codec makes clocks when gen is set
// Notes:   Counts slots per frame and sync-high slots for the bench

`timescale 1ns/1ps

// ************************************************************
// Codec model
// ************************************************************
module codec_model (
    input  wire logic        aux,        // Long sync framing
    input  wire logic        gen,        // Codec drives clock and sync
    input  wire logic [15:0] tx_word,    // Word sent on din
    input  wire logic        bclk,       // Resolved bit clock pin
    input  wire logic        fsync,      // Resolved frame sync pin
    input  wire logic        dout,       // Serial data from port
    output logic             din,        // Serial data to port
    output logic             bclk_d,     // Own bit clock
    output logic             fsync_d,    // Own frame sync
    output logic [15:0]      rx_word,    // Last word caught
    output int               frames,     // Words caught
    output int               frame_len,  // Slots in last frame
    output int               hi_len      // Sync-high slots in last frame
);
    int         slot = 99;   // Current slot
    int         hi = 0;      // Sync-high slots so far
    int         gslot = 0;   // Generator slot
    logic       fs_prev = 0; // Sync at previous rising edge
    logic [15:0] sh = 0;     // Receive shifter

    initial begin
        din = 0;
        bclk_d = 0;
        fsync_d = 0;
        rx_word = 0;
        frames = 0;
        frame_len = 0;
        hi_len = 0;
    end

    // Slave clocking: 32 slots of 4096 ns, runs without pause
    always begin
        #2048;
        if (gen) begin
            bclk_d = ~bclk_d;
            if (bclk_d) begin
                gslot = (gslot + 1) % 32;
                fsync_d = (gslot == 31);
            end
        end else begin
            bclk_d = 0;
        end
    end

    // Rising edge: find frame start, launch din
    always @(posedge bclk) begin
        #100;
        if (fsync !== fs_prev && fsync === aux) begin
            frame_len = slot + 1;
            hi_len = hi;
            hi = 0;
            slot = 0;
        end else begin
            slot = slot + 1;
        end
        fs_prev = fsync;
        hi = hi + int'(fsync === 1'b1);
        din = (slot < 16) ? tx_word[15 - slot] : ~din;
    end

    // Falling edge: sample dout MSB first
    always @(negedge bclk) begin
        if (slot < 16) begin
            sh[15 - slot] = dout;
        end
        if (slot == 15) begin
            rx_word = sh;
            frames++;
        end
    end
endmodule

// ---- voice_sample_serial_port_tb.sv ----
// Purpose: Self-checking bench of the voice sample serial port
// Assumes: APB master of 2-cycle transfers; codec model on the link
// Notes:   Each frame lasts about 131 us at the bench link clock

`timescale 1ns/1ps

module voice_sample_serial_port_tb;
    import voice_port_pkg::*;

    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, err, link_clk = 0;
    logic        bclk_o, bclk_oe_n, fsync_o, fsync_oe_n, din, dout;
    logic        cdc_aux = 0, cdc_gen = 0, cdc_bclk, cdc_fsync;
    logic [15:0] cdc_tx = 16'hA5C3, cdc_rx;
    int          cdc_frames, cdc_len, cdc_hi;
    int          failures = 0, samples_checked = 0;
    wire         bclk_pin = bclk_oe_n ? cdc_bclk : bclk_o;    // Pin level
    wire         fsync_pin = fsync_oe_n ? cdc_fsync : fsync_o; // Pin level

    // ************************************************************
    // Clocks and instances
    // ************************************************************
    initial forever #5 pclk = ~pclk;
    initial begin
        #13;
        forever #32 link_clk = ~link_clk;
    end

    voice_sample_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_clk(link_clk), .bclk_i(bclk_pin), .bclk_o(bclk_o),
        .bclk_oe_n(bclk_oe_n), .fsync_i(fsync_pin), .fsync_o(fsync_o), .fsync_oe_n(fsync_oe_n),
        .din(din), .dout(dout));

    codec_model codec (.aux(cdc_aux), .gen(cdc_gen), .tx_word(cdc_tx), .bclk(bclk_pin),
        .fsync(fsync_pin), .dout(dout), .din(din), .bclk_d(cdc_bclk), .fsync_d(cdc_fsync),
        .rx_word(cdc_rx), .frames(cdc_frames), .frame_len(cdc_len), .hi_len(cdc_hi));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, waits for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wait_frames(input int n);
        int f0, k;
        f0 = cdc_frames;
        k = 0;
        while (cdc_frames < f0 + n && k < 40000) begin
            @(posedge pclk);
            k++;
        end
        repeat (100) @(posedge pclk);  // Let the port hand its own word over
        check("frames", 32'(cdc_frames >= f0 + n), 1);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_regs();
        apb(0, CTRL_OFS, 0);
        check("ctrl reset", rd, 32'h0000001B);
        apb(0, STAT_OFS, 0);
        check("stat master", rd[STAT_MASTER_BIT], 1);
        check("stat aux", rd[STAT_AUX_BIT], 0);
        apb(0, 8'h10, 0);
        check("unmapped err", err, 1);
        check("unmapped data", rd, 0);
    endtask

    task automatic t_master_short();
        apb(1, TXD_OFS, 32'h00003C96);
        check("txd accepted", err, 0);
        apb(1, TXD_OFS, 32'h0000FFFF);
        check("busy txd refused", err, 1);
        wait_frames(2);
        check("short tx word", cdc_rx, 16'h3C96);
        check("short slots", cdc_len, 256);
        check("short sync", cdc_hi, 1);
        check("bclk drive", bclk_oe_n, 0);
        check("fsync drive", fsync_oe_n, 0);
        apb(0, STAT_OFS, 0);
        check("rx valid set", rd[STAT_RXV_BIT], 1);
        apb(0, RXD_OFS, 0);
        check("short rx word", rd, 32'h0000A5C3);
        apb(0, STAT_OFS, 0);
        check("rx valid cleared", rd[STAT_RXV_BIT], 0);
    endtask

    task automatic t_aux();
        apb(1, CTRL_OFS, 0);
        cdc_aux <= 1;
        cdc_tx <= 16'h7FFE;
        apb(1, CTRL_OFS, 32'h00000005);
        apb(0, CTRL_OFS, 0);
        check("ctrl aux", rd, 32'h00000005);
        apb(0, STAT_OFS, 0);
        check("aux forces master", rd[STAT_MASTER_BIT], 1);
        apb(1, TXD_OFS, 32'h00008001);
        wait_frames(2);
        check("aux tx word", cdc_rx, 16'h8001);
        check("aux slots", cdc_len, 32);
        check("aux sync half", cdc_hi, 16);
        apb(0, RXD_OFS, 0);
        check("aux rx word", rd, 32'h00007FFE);
    endtask

    task automatic t_slave();
        apb(1, CTRL_OFS, 0);
        cdc_aux <= 0;
        cdc_gen <= 1;
        cdc_tx <= 16'h1248;
        apb(1, CTRL_OFS, 32'h00000019);
        apb(1, TXD_OFS, 32'h00005AA5);
        apb(0, STAT_OFS, 0);
        check("slave role", rd[STAT_MASTER_BIT], 0);
        wait_frames(2);
        check("bclk released", bclk_oe_n, 1);
        check("fsync released", fsync_oe_n, 1);
        check("slave tx word", cdc_rx, 16'h5AA5);
        apb(0, RXD_OFS, 0);
        check("slave rx word", rd, 32'h00001248);
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (4) @(posedge link_clk);
        @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        t_reset_regs();
        t_master_short();
        t_aux();
        t_slave();
        tally_and_finish();
    end

    initial begin
        #950000;
        failures++;
        tally_and_finish();
    end
endmodule
